//--- rtl/burst_cache_pkg.sv
// Constants shared by the burst cache RAM port
package burst_cache_pkg;
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int LANE_W    = 8;
  localparam int LANES     = 2;
  localparam int WORD_W    = LANE_W + 1;
  localparam int DEPTH     = 65536;
  localparam int CNT_W     = 2;
  localparam int BURST_LEN = 4;
  localparam int LANE_LO   = 0;
  localparam int LANE_HI   = 1;
  localparam logic [CNT_W-1:0]  RST_CNT  = 2'h0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
  localparam logic [LANES-1:0]  RST_LANE = 2'h0;

  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_CPU_WAIT,
    PORT_BURST
  } port_mode_t;
endpackage

//--- rtl/burst_counter.sv
// Two-bit wraparound burst address counter
`timescale 1ns/1ps
`default_nettype none
module burst_counter
  import burst_cache_pkg::*;
#(
  parameter bit LINEAR = 1'h0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadValue,
  input  wire logic             step,
  output logic      [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] nextCount
);
  logic [CNT_W-1:0] first_ff;
  logic [CNT_W-1:0] idx_ff;
  logic [CNT_W-1:0] stepIdx;

  assign stepIdx = CNT_W'(idx_ff + 2'h1);

  // First address captured on load
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_ff <= RST_CNT;
    end else if (load) begin
      first_ff <= loadValue;
    end
  end

  // Position within the burst
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_ff <= RST_CNT;
    end else if (load) begin
      idx_ff <= RST_CNT;
    end else if (step) begin
      idx_ff <= stepIdx;
    end
  end

  // Order mapping of position to address
  always_comb begin
    if (LINEAR) begin
      count = CNT_W'(first_ff + idx_ff);
    end else begin
      count = first_ff ^ idx_ff;
    end
    if (load) begin
      nextCount = loadValue;
    end else if (step && LINEAR) begin
      nextCount = CNT_W'(first_ff + stepIdx);
    end else if (step) begin
      nextCount = first_ff ^ stepIdx;
    end else begin
      nextCount = count;
    end
  end

  property loadCapture;
    @(posedge clk_sys) disable iff (rst)
    load |=> count == $past(loadValue);
  endproperty
  count_load_a: assert property (loadCapture)
    else $error("Counter did not capture first address");

  property holdNoStep;
    @(posedge clk_sys) disable iff (rst)
    !load && !step |=> $stable(count);
  endproperty
  count_hold_a: assert property (holdNoStep)
    else $error("Counter moved without advance");

  property stepOrder;
    @(posedge clk_sys) disable iff (rst)
    !load && step |=> count == (LINEAR ?
      CNT_W'($past(count) + 2'h1) :
      ($past(first_ff) ^ CNT_W'($past(idx_ff) + 2'h1)));
  endproperty
  step_order_a: assert property (stepOrder)
    else $error("Burst order wrong");

  sequence fourSteps;
    (!load && step) [*4];
  endsequence
  property wrapAround;
    @(posedge clk_sys) disable iff (rst)
    fourSteps |=> count == $past(count, 4);
  endproperty
  burst_wrap_a: assert property (wrapAround)
    else $error("Counter did not wrap after four");
endmodule
`default_nettype wire

//--- rtl/sync_burst_cache_sram_port.sv
// Synchronous 64K x 18 burst cache RAM port with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
module sync_burst_cache_sram_port
  import burst_cache_pkg::*;
#(
  parameter bit LINEAR = 1'h0
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic              chipSelN,
  input  wire logic              cpu_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              upper_byte_write_n,
  input  wire logic              lower_byte_write_n,
  input  wire logic              burst_advance_n,
  input  wire logic              outEnableN,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic      [LANES-1:0]  dataOe,
  input  wire logic [LANES-1:0]  parity_io_in,
  output logic      [LANES-1:0]  parity_io_out,
  output logic      [LANES-1:0]  parity_io_oe
);
  // Byte-lane storage, parity bit above each data byte
  logic [WORD_W-1:0] memLo [0:DEPTH-1];
  logic [WORD_W-1:0] memHi [0:DEPTH-1];

  port_mode_t        mode_ff;
  logic [ADDR_W-1:0] addrReg_ff;
  logic              readMode_ff;
  logic [LANES-1:0]  laneWr_ff;
  logic [DATA_W-1:0] readData_ff;
  logic [LANES-1:0]  readPar_ff;

  logic              cpuStart;
  logic              ctrlStart;
  logic              startAccepted;
  logic              deselect;
  logic [LANES-1:0]  writeReq;
  logic [LANES-1:0]  wrLane;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] rdAddr;
  logic              advanceStep;
  logic [CNT_W-1:0]  burstCount;
  logic [CNT_W-1:0]  nxtBurstCount;

  assign writeReq = ~{upper_byte_write_n, lower_byte_write_n};

  // Strobe acceptance and priority
  assign cpuStart  = !chipSelN && !cpu_addr_strobe_n;
  assign ctrlStart = !chipSelN && cpu_addr_strobe_n
                     && !ctrl_addr_strobe_n;
  assign startAccepted = cpuStart || ctrlStart;
  assign deselect = chipSelN
                    && !(cpu_addr_strobe_n && ctrl_addr_strobe_n);
  assign advanceStep = !startAccepted && !burst_advance_n;

  burst_counter #(
    .LINEAR (LINEAR)
  ) u_counter (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .load      (startAccepted),
    .loadValue (addrIn[CNT_W-1:0]),
    .step      (advanceStep),
    .count     (burstCount),
    .nextCount (nxtBurstCount)
  );

  // Lane write enables and target address
  always_comb begin
    wrLane = RST_LANE;
    wrAddr = {addrReg_ff[ADDR_W-1:CNT_W], burstCount};
    if (cpuStart) begin
      wrLane = RST_LANE;
    end else if (ctrlStart) begin
      wrLane = writeReq;
      wrAddr = addrIn;
    end else if (deselect) begin
      wrLane = RST_LANE;
    end else if (mode_ff != PORT_IDLE) begin
      wrLane = writeReq;
    end
  end

  assign rdAddr = startAccepted ? addrIn
                  : {addrReg_ff[ADDR_W-1:CNT_W], nxtBurstCount};

  // Port mode sequencing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff <= PORT_IDLE;
    end else begin
      case (mode_ff)
        PORT_IDLE, PORT_CPU_WAIT, PORT_BURST: begin
          if (cpuStart) begin
            mode_ff <= PORT_CPU_WAIT;
          end else if (ctrlStart) begin
            mode_ff <= PORT_BURST;
          end else if (deselect) begin
            mode_ff <= PORT_IDLE;
          end else if (mode_ff == PORT_CPU_WAIT) begin
            mode_ff <= PORT_BURST;
          end
        end
        default: begin
          mode_ff <= PORT_IDLE;
        end
      endcase
    end
  end

  // Full address capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addrReg_ff <= RST_ADDR;
    end else if (startAccepted) begin
      addrReg_ff <= addrIn;
    end
  end

  // Read qualification
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readMode_ff <= 1'h0;
    end else if (cpuStart) begin
      readMode_ff <= 1'h1;
    end else if (ctrlStart) begin
      readMode_ff <= !(|writeReq);
    end else if (deselect) begin
      readMode_ff <= 1'h0;
    end
  end

  // Lanes sampled for writing this cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      laneWr_ff <= RST_LANE;
    end else begin
      laneWr_ff <= writeReq;
    end
  end

  // Array write per byte lane
  always_ff @(posedge clk_sys) begin
    if (wrLane[LANE_LO]) begin
      memLo[wrAddr] <= {parity_io_in[LANE_LO], dataIn[LANE_W-1:0]};
    end
    if (wrLane[LANE_HI]) begin
      memHi[wrAddr] <= {parity_io_in[LANE_HI], dataIn[DATA_W-1:LANE_W]};
    end
  end

  // Registered read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readData_ff <= RST_DATA;
      readPar_ff  <= RST_LANE;
    end else begin
      readData_ff <= {memHi[rdAddr][LANE_W-1:0], memLo[rdAddr][LANE_W-1:0]};
      readPar_ff  <= {memHi[rdAddr][LANE_W], memLo[rdAddr][LANE_W]};
    end
  end

  // Output drive, output enable acts combinationally
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      dataOe[i] = readMode_ff && (mode_ff != PORT_IDLE)
                  && !outEnableN && !laneWr_ff[i];
    end
  end
  assign parity_io_oe  = dataOe;
  assign dataOut       = readData_ff;
  assign parity_io_out = readPar_ff;

  property cpuStartIgnoresWrite;
    @(posedge clk_sys) disable iff (rst)
    cpuStart |-> wrLane == RST_LANE;
  endproperty
  start_wr_ign_a: assert property (cpuStartIgnoresWrite)
    else $error("Write taken in processor start cycle");

  sequence cpuSecondWrite;
    cpuStart ##1 (cpu_addr_strobe_n && ctrl_addr_strobe_n
                  && (|writeReq));
  endsequence
  property cpuWriteTwoCycles;
    @(posedge clk_sys) disable iff (rst)
    cpuSecondWrite |-> wrLane == writeReq
      && wrAddr == $past(addrIn);
  endproperty
  cpu_write_two_a: assert property (cpuWriteTwoCycles)
    else $error("Processor write missing in second period");

  property csGatesCpu;
    @(posedge clk_sys) disable iff (rst)
    chipSelN |-> !startAccepted ##1 $stable(addrReg_ff);
  endproperty
  cs_gate_a: assert property (csGatesCpu)
    else $error("Strobe taken with chip select high");

  property lowLaneStore;
    @(posedge clk_sys) disable iff (rst)
    wrLane[LANE_LO] |=> memLo[$past(wrAddr)]
      == {$past(parity_io_in[LANE_LO]), $past(dataIn[LANE_W-1:0])};
  endproperty
  lane_store_a: assert property (lowLaneStore)
    else $error("Low lane not stored");

  property writeTristates;
    @(posedge clk_sys) disable iff (rst)
    !upper_byte_write_n |=> !dataOe[LANE_HI] && !parity_io_oe[LANE_HI];
  endproperty
  write_tristate_a: assert property (writeTristates)
    else $error("Lane driven during write");

  property ctrlSingleWrite;
    @(posedge clk_sys) disable iff (rst)
    ctrlStart && !lower_byte_write_n |->
      wrLane[LANE_LO] && wrAddr == addrIn;
  endproperty
  ctrl_write_a: assert property (ctrlSingleWrite)
    else $error("Controller write not immediate");

  property addrLoad;
    @(posedge clk_sys) disable iff (rst)
    startAccepted |=> addrReg_ff == $past(addrIn)
      && burstCount == $past(addrIn[CNT_W-1:0]);
  endproperty
  addr_load_a: assert property (addrLoad)
    else $error("Address not loaded on strobe");

  property readStart;
    @(posedge clk_sys) disable iff (rst)
    ctrlStart && !(|writeReq) ##1 (!outEnableN && !(|laneWr_ff))
      |-> dataOe == 2'h3;
  endproperty
  read_start_a: assert property (readStart)
    else $error("Read data not driven");

  property oeAsync;
    @(posedge clk_sys) disable iff (rst)
    outEnableN |-> dataOe == RST_LANE && parity_io_oe == RST_LANE;
  endproperty
  oe_async_a: assert property (oeAsync)
    else $error("Driving with output enable high");

  property cpuPriority;
    @(posedge clk_sys) disable iff (rst)
    !chipSelN && !cpu_addr_strobe_n && !ctrl_addr_strobe_n
      |=> mode_ff == PORT_CPU_WAIT;
  endproperty
  strobe_prio_a: assert property (cpuPriority)
    else $error("Controller strobe won over processor");
endmodule
`default_nettype wire

//--- tb/host_bus_model.sv
// Host pin model for the shared data and parity lines
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import burst_cache_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     outEnableN,
  input  wire logic                     hostDrive,
  input  wire logic [DATA_W+LANES-1:0]  hostWord,
  input  wire logic [DATA_W-1:0]        devData,
  input  wire logic [LANES-1:0]         devPar,
  input  wire logic [LANES-1:0]         devOe,
  output logic      [DATA_W+LANES-1:0]  pinWord
);
  logic [DATA_W+LANES-1:0] lastWord = '0;
  // Undriven lanes show the inverse of the last level
  always_comb begin
    pinWord = ~lastWord;
    for (int l = 0; l < LANES; l++) begin
      if (hostDrive && outEnableN) begin
        pinWord[l*LANE_W +: LANE_W] = hostWord[l*LANE_W +: LANE_W];
        pinWord[DATA_W+l] = hostWord[DATA_W+l];
      end else if (devOe[l]) begin
        pinWord[l*LANE_W +: LANE_W] = devData[l*LANE_W +: LANE_W];
        pinWord[DATA_W+l] = devPar[l];
      end
    end
  end
  always @(posedge clk_sys) lastWord <= pinWord;
endmodule
`default_nettype wire

//--- tb/sync_burst_cache_sram_port_tb.sv
// Self-checking bench for the burst cache RAM port
`timescale 1ns/1ps
`default_nettype none
module sync_burst_cache_sram_port_tb
  import burst_cache_pkg::*;
();
  typedef logic [DATA_W+LANES-1:0] word_t;
  localparam logic L = 1'h0;
  localparam logic H = 1'h1;
  logic              clk_sys = 1'h0;
  logic              rst = 1'h1;
  logic [ADDR_W-1:0] addrIn = RST_ADDR;
  logic [6:0]        pins = 7'h7F;
  logic              hostDrive = 1'h0;
  word_t             hostWord = '0;
  word_t             shadow [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] a;
  word_t             w;
  int                mismatches = 0;
  int                cmp_count = 0;
  integer            seed = 65;
  wire word_t        pinWord, out0, out1;
  wire [LANES-1:0]   oe0, oe1, poe0, poe1;
  wire chipSelN, cpu_addr_strobe_n, ctrl_addr_strobe_n, upper_byte_write_n;
  wire lower_byte_write_n, burst_advance_n, outEnableN;
  assign {chipSelN, cpu_addr_strobe_n, ctrl_addr_strobe_n, upper_byte_write_n,
    lower_byte_write_n, burst_advance_n, outEnableN} = pins;
  always #50 clk_sys = ~clk_sys;

  sync_burst_cache_sram_port #(.LINEAR(1'h0)) sync_burst_cache_sram_port_i (
    .clk_sys, .rst, .addrIn, .chipSelN, .cpu_addr_strobe_n,
    .ctrl_addr_strobe_n, .upper_byte_write_n, .lower_byte_write_n,
    .burst_advance_n, .outEnableN, .dataIn(pinWord[DATA_W-1:0]),
    .dataOut(out0[DATA_W-1:0]), .dataOe(oe0),
    .parity_io_in(pinWord[DATA_W+:LANES]),
    .parity_io_out(out0[DATA_W+:LANES]), .parity_io_oe(poe0));
  sync_burst_cache_sram_port #(.LINEAR(1'h1)) sync_burst_cache_sram_port_li (
    .clk_sys, .rst, .addrIn, .chipSelN, .cpu_addr_strobe_n,
    .ctrl_addr_strobe_n, .upper_byte_write_n, .lower_byte_write_n,
    .burst_advance_n, .outEnableN, .dataIn(pinWord[DATA_W-1:0]),
    .dataOut(out1[DATA_W-1:0]), .dataOe(oe1),
    .parity_io_in(pinWord[DATA_W+:LANES]),
    .parity_io_out(out1[DATA_W+:LANES]), .parity_io_oe(poe1));
  host_bus_model host_bus_model_i (.clk_sys, .outEnableN, .hostDrive,
    .hostWord, .devData(out0[DATA_W-1:0]), .devPar(out0[DATA_W+:LANES]),
    .devOe(oe0), .pinWord);

  function automatic logic [6:0] pk(logic cs, cpu, ctl, logic [1:0] wm,
                                    logic stp, oe);
    return {cs, cpu, ctl, ~wm, stp, oe};
  endfunction
  function automatic word_t merge(word_t o, word_t n, logic [1:0] m);
    word_t r;
    r = o;
    for (int l = 0; l < LANES; l++) begin
      if (m[l]) begin
        r[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
        r[DATA_W+l] = n[DATA_W+l];
      end
    end
    return r;
  endfunction
  function automatic word_t rw();
    return word_t'($random(seed));
  endfunction
  function automatic logic [ADDR_W-1:0] ra();
    return ADDR_W'($random(seed));
  endfunction

  task automatic drv(logic [6:0] p, logic dr, logic [ADDR_W-1:0] ad,
                     word_t wd);
    @(posedge clk_sys);
    pins <= p;
    hostDrive <= dr;
    addrIn <= ad;
    hostWord <= wd;
  endtask
  task automatic chk(word_t e0, word_t e1, logic [LANES-1:0] eo);
    word_t mk;
    #1;
    mk = '0;
    for (int l = 0; l < LANES; l++) begin
      if (eo[l]) begin
        mk[l*LANE_W +: LANE_W] = '1;
        mk[DATA_W+l] = 1'h1;
      end
    end
    cmp_count++;
    if (oe0 !== eo || oe1 !== eo || poe0 !== eo || poe1 !== eo ||
        (out0 & mk) !== (e0 & mk) || (out1 & mk) !== (e1 & mk)) begin
      mismatches++;
      $display("BAD %0t got %h/%h oe %b want %h/%h oe %b", $time,
               out0, out1, oe0, e0, e1, eo);
    end
  endtask
  task automatic wrc(logic [ADDR_W-1:0] ad, word_t wd, logic [1:0] m);
    drv(pk(L, H, L, m, H, H), H, ad, wd);
    shadow[ad] = merge(shadow[ad], wd, m);
  endtask
  task automatic rd1(logic [ADDR_W-1:0] ad);
    drv(pk(L, H, L, 2'h0, H, L), L, ad, rw());
    drv(pk(L, H, H, 2'h0, H, L), L, ad, rw());
    chk(shadow[ad], shadow[ad], 2'h3);
  endtask
  task automatic rdb(logic [ADDR_W-1:0] b, logic [1:0] s);
    logic [1:0] k2;
    drv(pk(L, H, L, 2'h0, H, L), L, {b[ADDR_W-1:2], s}, rw());
    for (int k = 0; k < 6; k++) begin
      drv(pk(L, H, H, 2'h0, logic'(k >= 4), L), L, ra(), rw());
      k2 = (k > 4) ? 2'h0 : 2'(k);
      chk(shadow[{b[ADDR_W-1:2], s ^ k2}],
          shadow[{b[ADDR_W-1:2], s + k2}], 2'h3);
    end
    drv(pk(L, H, H, 2'h0, H, H), L, ra(), rw());
    chk('0, '0, 2'h0);
    drv(pk(L, H, H, 2'h0, H, L), L, ra(), rw());
    chk(shadow[{b[ADDR_W-1:2], s}], shadow[{b[ADDR_W-1:2], s}], 2'h3);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(100 * 4000);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    for (int n = 0; n < 8; n++) begin
      a = ra();
      for (int k = 0; k < 4; k++) wrc({a[15:2], 2'(k)}, rw(), 2'h3);
      rdb(a, 2'(n));
    end
    $display("test burst done");
    for (int m = 1; m < 4; m++) begin
      a = ra();
      w = rw();
      wrc(a, rw(), 2'h3);
      drv(pk(L, L, H, 2'h3, H, H), H, a, rw());
      drv(pk(L, H, H, 2'(m), H, H), H, ra(), w);
      drv(pk(L, H, H, 2'h0, H, L), L, ra(), rw());
      chk(shadow[a], shadow[a], ~2'(m));
      shadow[a] = merge(shadow[a], w, 2'(m));
      rd1(a);
    end
    $display("test lanes done");
    a = ra();
    wrc(a, rw(), 2'h3);
    drv(pk(L, L, L, 2'h3, H, H), H, a, rw());
    drv(pk(H, L, H, 2'h3, H, H), H, a, rw());
    drv(pk(H, H, L, 2'h3, H, H), H, a, rw());
    drv(pk(L, H, H, 2'h3, H, H), H, a, rw());
    drv(pk(H, H, H, 2'h0, H, L), L, a, rw());
    chk('0, '0, 2'h0);
    rd1(a);
    $display("test select done");
    give_verdict();
  end
endmodule
`default_nettype wire
